// File: common/irq_seq_pkg.sv
// constants and types shared by the vectored interrupt sequencer
package irq_seq_pkg;
    localparam int          NSRC          = 4;        // request sources
    localparam int          IN_PAGE_W     = 7;        // in-page address width
    localparam int          PAGE_W_DEF    = 6;        // default page field width
    localparam int          DP_W_DEF      = 10;       // default data pointer width
    localparam int          ACC_W         = 4;        // accumulator width
    localparam int          ADDR_W        = 8;        // apb address width
    // source indices, also priority order (lowest index wins)
    localparam int          SRC_PIN       = 0;
    localparam int          SRC_T1        = 1;
    localparam int          SRC_T2        = 2;
    localparam int          SRC_T3        = 3;
    // apb register byte offsets
    localparam logic [7:0]  OFS_EN_A      = 8'h00;    // irq_enable_reg_a
    localparam logic [7:0]  OFS_EN_B      = 8'h04;    // irq_enable_reg_b
    localparam logic [7:0]  OFS_STATUS    = 8'h08;    // sticky events, write one to clear
    localparam logic [7:0]  OFS_MASK      = 8'h0C;    // event mask
    localparam logic [7:0]  OFS_STATE     = 8'h10;    // read-only core state
    localparam logic [7:0]  OFS_EDGE      = 8'h14;    // pin edge selection
    // enable register field positions
    localparam int          EN_A_PIN_BIT  = 0;        // pin_edge_irq_enable_bit
    localparam int          EN_A_T1_BIT   = 2;        // first_timer_irq_enable_bit
    localparam int          EN_A_T2_BIT   = 3;        // second_timer_irq_enable_bit
    localparam int          EN_B_T3_BIT   = 0;        // third_timer_irq_enable_bit
    localparam logic [3:0]  EN_RST        = 4'h0;     // enables reset value
    // status and mask layout
    localparam int          STAT_W        = 5;
    localparam int          STAT_TAKEN    = 4;        // bit 4: an interrupt was taken
    localparam logic [4:0]  STAT_RST      = 5'h00;
    // state register field positions
    localparam int          ST_GIE_BIT    = 0;
    localparam int          ST_EIP_BIT    = 1;
    localparam int          ST_CTX_BIT    = 2;
    // pin edge selection codes
    localparam logic [1:0]  EDGE_FALL     = 2'h0;
    localparam logic [1:0]  EDGE_RISE     = 2'h1;
    localparam logic [1:0]  EDGE_BOTH     = 2'h2;
    localparam logic [1:0]  EDGE_RST      = 2'h0;
    // vectors: page 1, in-page offsets per source
    localparam int          VEC_PAGE      = 1;
    localparam logic [6:0]  VEC_PIN       = 7'h00;
    localparam logic [6:0]  VEC_T1        = 7'h04;
    localparam logic [6:0]  VEC_T2        = 7'h06;
    localparam logic [6:0]  VEC_T3        = 7'h08;
    // program memory window held for vectors
    localparam logic [15:0] VEC_RANGE_LO  = 16'h0080;
    localparam logic [15:0] VEC_RANGE_HI  = 16'h00FF;
    // start latency in machine cycles
    localparam logic [1:0]  LAT_SHORT     = 2'h2;
    localparam logic [1:0]  LAT_LONG      = 2'h3;
    // sequencer states
    typedef enum logic {seq_idle, seq_wait} seq_state_t;
endpackage

// File: logic/vectored_irq_sequencer.sv
// vectored interrupt sequencer with program counter, context save and apb registers
`timescale 1ns/1ps
module vectored_irq_sequencer
    import irq_seq_pkg::*;
#(
    parameter int PAGE_W = irq_seq_pkg::PAGE_W_DEF,       // page part width
    parameter int DP_W   = irq_seq_pkg::DP_W_DEF          // data pointer width
) (
    input  wire logic                                 pclk,
    input  wire logic                                 presetn,
    input  wire logic                                 ce,
    input  wire logic                                 psel,
    input  wire logic                                 penable,
    input  wire logic                                 pwrite,
    input  wire logic [irq_seq_pkg::ADDR_W-1:0]       paddr,
    input  wire logic [31:0]                          pwdata,
    output logic      [31:0]                          prdata,
    output logic                                      pready,
    output logic                                      pslverr,
    output logic                                      irq,
    input  wire logic                                 pin_edge_in,
    input  wire logic [2:0]                           timer_underflow,
    input  wire logic                                 mc_tick,
    input  wire logic                                 instr_done,
    input  wire logic                                 instr_multi,
    input  wire logic [1:0]                           instr_words,
    input  wire logic                                 branch_load,
    input  wire logic [PAGE_W+irq_seq_pkg::IN_PAGE_W-1:0] branch_target,
    input  wire logic                                 irq_on_instr,
    input  wire logic                                 irq_off_instr,
    input  wire logic                                 irq_return_instr,
    input  wire logic [irq_seq_pkg::NSRC-1:0]         skip_test,
    output logic                                      skip_taken,
    input  wire logic [PAGE_W+irq_seq_pkg::IN_PAGE_W-1:0] return_stack_pop,
    output logic                                      stack_push,
    output logic      [PAGE_W+irq_seq_pkg::IN_PAGE_W-1:0] return_stack_entry,
    output logic      [PAGE_W-1:0]                    pc_page_part,
    output logic      [irq_seq_pkg::IN_PAGE_W-1:0]    pc_in_page_part,
    input  wire logic [DP_W-1:0]                      ctx_dp,
    input  wire logic                                 ctx_carry,
    input  wire logic                                 ctx_skip,
    input  wire logic [irq_seq_pkg::ACC_W-1:0]        ctx_acc_a,
    input  wire logic [irq_seq_pkg::ACC_W-1:0]        ctx_acc_b,
    output logic                                      restore_valid,
    output logic      [DP_W-1:0]                      restore_dp,
    output logic                                      restore_carry,
    output logic                                      restore_skip,
    output logic      [irq_seq_pkg::ACC_W-1:0]        restore_acc_a,
    output logic      [irq_seq_pkg::ACC_W-1:0]        restore_acc_b,
    output logic                                      irq_taken,
    output logic      [1:0]                           irq_source,
    output logic                                      global_irq_enable,
    output logic                                      pin_edge_request_flag,
    output logic                                      first_timer_request_flag,
    output logic                                      second_timer_request_flag,
    output logic                                      third_timer_request_flag
);
    import irq_seq_pkg::*;

    localparam int PC_W = PAGE_W + IN_PAGE_W;                 // full program counter width
    localparam int CTX_W = DP_W + 2 + 2 * ACC_W;              // saved context width

    // lowest set index wins; pin edge first
    function automatic logic [1:0] pick_src(input logic [NSRC-1:0] req);
        logic [1:0] idx;
        idx = 2'h0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                idx = 2'(i);
            end
        end
        return idx;
    endfunction

    // vector address of a source
    function automatic logic [PC_W-1:0] vec_of(input logic [1:0] src);
        logic [IN_PAGE_W-1:0] ofs;
        case (src)
            2'h0:    ofs = VEC_PIN;
            2'h1:    ofs = VEC_T1;
            2'h2:    ofs = VEC_T2;
            default: ofs = VEC_T3;
        endcase
        return {PAGE_W'(VEC_PAGE), ofs};
    endfunction

    // registered state
    logic [1:0]       pin_sync_r;          // two-stage pin synchroniser
    logic [1:0]       pin_sync_nxt;
    logic             pin_prev_r;          // previous synchronised level
    logic             pin_prev_nxt;
    logic [NSRC-1:0]  req_r;               // request flags
    logic [NSRC-1:0]  req_nxt;
    logic [3:0]       en_a_r;              // irq_enable_reg_a
    logic [3:0]       en_a_nxt;
    logic [3:0]       en_b_r;              // irq_enable_reg_b
    logic [3:0]       en_b_nxt;
    logic [1:0]       edge_r;              // pin edge selection
    logic [1:0]       edge_nxt;
    logic [STAT_W-1:0] stat_r;             // sticky event bits
    logic [STAT_W-1:0] stat_nxt;
    logic [STAT_W-1:0] mask_r;             // event mask
    logic [STAT_W-1:0] mask_nxt;
    logic             gie_r;               // global enable
    logic             gie_nxt;
    logic             eip_r;               // enable waiting for one instruction
    logic             eip_nxt;
    seq_state_t       st_r;                // start sequencer
    seq_state_t       st_nxt;
    logic [1:0]       lat_r;               // machine cycles left
    logic [1:0]       lat_nxt;
    logic [PC_W-1:0]  pc_r;                // program counter
    logic [PC_W-1:0]  pc_nxt;
    logic [CTX_W-1:0] ctx_r;               // irq_context_save
    logic [CTX_W-1:0] ctx_nxt;
    logic             ctxv_r;              // context holds a live frame
    logic             ctxv_nxt;
    logic [31:0]      rd_r;                // read data
    logic [31:0]      rd_nxt;
    logic             err_r;               // unmapped access answer
    logic             err_nxt;
    logic             push_r;
    logic             push_nxt;
    logic [PC_W-1:0]  push_data_r;
    logic [PC_W-1:0]  push_data_nxt;
    logic             rest_r;
    logic             rest_nxt;
    logic             take_r;
    logic             take_nxt;
    logic [1:0]       src_r;
    logic [1:0]       src_nxt;
    logic             skip_r;
    logic             skip_nxt;

    // combinational helpers
    logic [NSRC-1:0]  en_vec;              // per-source enable in source order
    logic [NSRC-1:0]  src_set;             // activation events this cycle
    logic [NSRC-1:0]  ready_req;           // flags allowed to interrupt
    logic             pin_edge;
    logic             setup;
    logic             wr_acc;
    logic             mapped;
    logic [1:0]       win;
    logic             take;
    logic [PC_W-1:0]  pc_adv;

    // next values of all state
    always_comb begin
        pin_sync_nxt  = {pin_sync_r[0], pin_edge_in};
        pin_prev_nxt  = pin_sync_r[1];
        req_nxt       = req_r;
        en_a_nxt      = en_a_r;
        en_b_nxt      = en_b_r;
        edge_nxt      = edge_r;
        stat_nxt      = stat_r;
        mask_nxt      = mask_r;
        gie_nxt       = gie_r;
        eip_nxt       = eip_r;
        st_nxt        = st_r;
        lat_nxt       = lat_r;
        pc_nxt        = pc_r;
        ctx_nxt       = ctx_r;
        ctxv_nxt      = ctxv_r;
        rd_nxt        = rd_r;
        err_nxt       = err_r;
        push_nxt      = 1'b0;
        push_data_nxt = push_data_r;
        rest_nxt      = 1'b0;
        take_nxt      = 1'b0;
        src_nxt       = src_r;
        skip_nxt      = 1'b0;
        take          = 1'b0;
        // enable bits gathered from both control registers
        // two enable registers
        en_vec = {en_b_r[EN_B_T3_BIT], en_a_r[EN_A_T2_BIT], en_a_r[EN_A_T1_BIT], en_a_r[EN_A_PIN_BIT]};
        // edge detect on the second synchroniser stage only
        case (edge_r)
            EDGE_FALL: pin_edge = pin_prev_r & ~pin_sync_r[1];
            EDGE_RISE: pin_edge = ~pin_prev_r & pin_sync_r[1];
            EDGE_BOTH: pin_edge = pin_prev_r ^ pin_sync_r[1];
            default:   pin_edge = 1'b0;
        endcase
        src_set = {timer_underflow, pin_edge};
        ready_req = req_r & en_vec & {NSRC{gie_r}};
        win = pick_src(ready_req);
        pc_adv = pc_r + PC_W'(instr_words);
        // start sequencer: latency counted in machine cycles
        case (st_r)
            seq_idle: begin
                if (|ready_req) begin
                    lat_nxt = instr_multi ? LAT_LONG : LAT_SHORT;
                    st_nxt  = seq_wait;
                end
            end
            seq_wait: begin
                if (!(|ready_req)) begin
                    // condition withdrawn before the start
                    st_nxt = seq_idle;
                end else if (mc_tick) begin
                    if (lat_r == 2'h1) begin
                        take   = 1'b1;
                        st_nxt = seq_idle;
                    end else begin
                        lat_nxt = lat_r - 2'h1;
                    end
                end
            end
            default: st_nxt = seq_idle;
        endcase
        if (instr_done) begin
            pc_nxt = branch_load ? branch_target : pc_adv;
        end
        if (irq_return_instr) begin
            pc_nxt   = return_stack_pop;
            rest_nxt = ctxv_r;
            ctxv_nxt = 1'b0;
        end
        if (take) begin
            push_nxt      = 1'b1;
            push_data_nxt = pc_nxt;
            pc_nxt        = vec_of(win);
            ctx_nxt       = {ctx_dp, ctx_carry, ctx_skip, ctx_acc_a, ctx_acc_b};
            ctxv_nxt      = 1'b1;
            take_nxt      = 1'b1;
            src_nxt       = win;
        end
        // global enable handling
        if (irq_on_instr) begin
            eip_nxt = 1'b1;
        end else if (eip_r && instr_done) begin
            gie_nxt = 1'b1;
            eip_nxt = 1'b0;
        end
        if (irq_off_instr) begin
            gie_nxt = 1'b0;
            eip_nxt = 1'b0;
        end
        if (take) begin
            gie_nxt = 1'b0;
        end
        // request flag clears
        for (int i = 0; i < NSRC; i++) begin
            if (skip_test[i] && !en_vec[i] && req_r[i]) begin
                req_nxt[i] = 1'b0;
                skip_nxt   = 1'b1;
            end
        end
        if (take) begin
            req_nxt[win] = 1'b0;
        end
        req_nxt = req_nxt | src_set;
        // apb decode
        setup  = psel && !penable;
        wr_acc = psel && penable && pwrite;
        case (paddr)
            OFS_EN_A, OFS_EN_B, OFS_STATUS, OFS_MASK, OFS_STATE, OFS_EDGE: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
        if (setup) begin
            // read data captured at setup, shown in the access phase
            err_nxt = !mapped;
            case (paddr)
                OFS_EN_A:   rd_nxt = {28'h0000000, en_a_r};
                OFS_EN_B:   rd_nxt = {28'h0000000, en_b_r};
                OFS_STATUS: rd_nxt = {27'h0000000, stat_r};
                OFS_MASK:   rd_nxt = {27'h0000000, mask_r};
                OFS_STATE:  rd_nxt = {29'h00000000, ctxv_r, eip_r, gie_r};
                OFS_EDGE:   rd_nxt = {30'h00000000, edge_r};
                default:    rd_nxt = 32'h00000000;
            endcase
        end
        // write-one-to-clear before new events so set wins
        if (wr_acc && paddr == OFS_STATUS) begin
            stat_nxt = stat_r & ~pwdata[STAT_W-1:0];
        end
        stat_nxt = stat_nxt | {take, src_set};
        if (wr_acc) begin
            case (paddr)
                OFS_EN_A: en_a_nxt = pwdata[3:0];
                OFS_EN_B: en_b_nxt = pwdata[3:0];
                OFS_MASK: mask_nxt = pwdata[STAT_W-1:0];
                OFS_EDGE: edge_nxt = pwdata[1:0];
                default:  ;
            endcase
        end
    end

    // registers, frozen while ce is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_sync_r  <= 2'h0;
            pin_prev_r  <= 1'b0;
            req_r       <= 4'h0;
            en_a_r      <= EN_RST;
            en_b_r      <= EN_RST;
            edge_r      <= EDGE_RST;
            stat_r      <= STAT_RST;
            mask_r      <= STAT_RST;
            gie_r       <= 1'b0;
            eip_r       <= 1'b0;
            st_r        <= seq_idle;
            lat_r       <= 2'h0;
            pc_r        <= '0;
            ctx_r       <= '0;
            ctxv_r      <= 1'b0;
            rd_r        <= 32'h00000000;
            err_r       <= 1'b0;
            push_r      <= 1'b0;
            push_data_r <= '0;
            rest_r      <= 1'b0;
            take_r      <= 1'b0;
            src_r       <= 2'h0;
            skip_r      <= 1'b0;
        end else if (ce) begin
            pin_sync_r  <= pin_sync_nxt;
            pin_prev_r  <= pin_prev_nxt;
            req_r       <= req_nxt;
            en_a_r      <= en_a_nxt;
            en_b_r      <= en_b_nxt;
            edge_r      <= edge_nxt;
            stat_r      <= stat_nxt;
            mask_r      <= mask_nxt;
            gie_r       <= gie_nxt;
            eip_r       <= eip_nxt;
            st_r        <= st_nxt;
            lat_r       <= lat_nxt;
            pc_r        <= pc_nxt;
            ctx_r       <= ctx_nxt;
            ctxv_r      <= ctxv_nxt;
            rd_r        <= rd_nxt;
            err_r       <= err_nxt;
            push_r      <= push_nxt;
            push_data_r <= push_data_nxt;
            rest_r      <= rest_nxt;
            take_r      <= take_nxt;
            src_r       <= src_nxt;
            skip_r      <= skip_nxt;
        end
    end

    // output wiring
    assign prdata                    = rd_r;
    assign pready                    = 1'b1;
    assign pslverr                   = psel && penable && err_r;
    assign irq                       = |(stat_r & mask_r);
    assign skip_taken                = skip_r;
    assign stack_push                = push_r;
    assign return_stack_entry        = push_data_r;
    assign pc_page_part              = pc_r[PC_W-1:IN_PAGE_W];
    assign pc_in_page_part           = pc_r[IN_PAGE_W-1:0];
    assign restore_valid             = rest_r;
    assign restore_dp                = ctx_r[CTX_W-1:CTX_W-DP_W];
    assign restore_carry             = ctx_r[2*ACC_W+1];
    assign restore_skip              = ctx_r[2*ACC_W];
    assign restore_acc_a             = ctx_r[2*ACC_W-1:ACC_W];
    assign restore_acc_b             = ctx_r[ACC_W-1:0];
    assign irq_taken                 = take_r;
    assign irq_source                = src_r;
    assign global_irq_enable         = gie_r;
    assign pin_edge_request_flag     = req_r[SRC_PIN];
    assign first_timer_request_flag  = req_r[SRC_T1];
    assign second_timer_request_flag = req_r[SRC_T2];
    assign third_timer_request_flag  = req_r[SRC_T3];
endmodule

// File: testbench/irq_seq_checker.sv
// concurrent checks on the ports of the interrupt sequencer
`timescale 1ns/1ps
module irq_seq_checker
    import irq_seq_pkg::*;
#(
    parameter int PAGE_W = PAGE_W_DEF   // page part width
) (
    input logic                   pclk, presetn, psel, penable, pslverr, skip_taken,
    input logic [7:0]             paddr,
    input logic [2:0]             timer_underflow,
    input logic                   irq_off_instr, stack_push, restore_valid, irq_taken,
    input logic                   global_irq_enable, pin_edge_request_flag, first_timer_request_flag,
    input logic [1:0]             irq_source,
    input logic [PAGE_W+6:0]      return_stack_pop,
    input logic [PAGE_W-1:0]      pc_page_part,
    input logic [6:0]             pc_in_page_part
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_take_clears_gie: assert property (irq_taken |-> !global_irq_enable)
        else $error("global enable left set after a take");
    a_take_page_one: assert property (irq_taken |-> pc_page_part == VEC_PAGE)
        else $error("vector page wrong");
    a_take_vector_ofs: assert property (irq_taken |-> pc_in_page_part == (irq_source == 2'h0 ? VEC_PIN :
        irq_source == 2'h1 ? VEC_T1 : irq_source == 2'h2 ? VEC_T2 : VEC_T3)) else $error("vector offset wrong");
    a_push_on_take: assert property (irq_taken |-> stack_push)
        else $error("no push on take");
    a_served_pin_clear: assert property (irq_taken && irq_source == 2'h0 |-> !pin_edge_request_flag)
        else $error("served pin flag still set");
    a_timer_sets_flag: assert property (timer_underflow[0] |=> first_timer_request_flag)
        else $error("timer flag not set");
    a_flag_clear_cause: assert property ($fell(first_timer_request_flag) |->
        (irq_taken && irq_source == 2'h1) || skip_taken) else $error("timer flag dropped without cause");
    a_gie_off_instr: assert property (irq_off_instr |=> !global_irq_enable)
        else $error("disable did not clear global enable");
    a_return_pc_pop: assert property (restore_valid |-> {pc_page_part, pc_in_page_part} == $past(return_stack_pop))
        else $error("return address not loaded");
    a_unmapped_err: assert property (psel && penable && paddr > OFS_EDGE |-> pslverr)
        else $error("unmapped access without error");
endmodule

// File: testbench/cpu_seq_model.sv
// behavioural instruction sequencer and one-deep return stack facing the block
`timescale 1ns/1ps
module cpu_seq_model #(
    parameter int PC_W = 13   // program counter width
) (
    input  logic            pclk, presetn, stack_push,
    input  logic [PC_W-1:0] return_stack_entry,
    output logic            mc_tick, instr_done, instr_multi, ctx_carry, ctx_skip,
    output logic [1:0]      instr_words,
    output logic [PC_W-1:0] return_stack_pop,
    output logic [9:0]      ctx_dp,
    output logic [3:0]      ctx_acc_a, ctx_acc_b
);
    logic [1:0]      cnt_r, cnt_nxt;   // machine cycle phase
    logic [PC_W-1:0] top_r, top_nxt;   // stack top
    // phase advance and push capture
    always_comb begin
        cnt_nxt = cnt_r + 2'h1;
        top_nxt = stack_push ? return_stack_entry : top_r;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 2'h0;
            top_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
            top_r <= top_nxt;
        end
    end
    // one-word instructions, multi-cycle every other one
    assign mc_tick = cnt_r[0];
    assign instr_done = cnt_r[0];
    assign instr_multi = cnt_r[1];
    assign instr_words = 2'h1;
    assign return_stack_pop = top_r;
    // fixed live context, seen again on return
    assign ctx_dp = 10'h2A5;
    assign ctx_carry = 1'b1;
    assign ctx_skip = 1'b0;
    assign ctx_acc_a = 4'h9;
    assign ctx_acc_b = 4'h6;
endmodule

// File: testbench/vectored_irq_sequencer_test.sv
// self-checking bench for the vectored interrupt sequencer
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %s expected %0h seen %0h", n, e, a); end end
module vectored_irq_sequencer_test;
    import irq_seq_pkg::*;
    logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, pin_edge_in = 1, branch_load = 0;
    logic irq_on_instr = 0, irq_off_instr = 0, irq_return_instr = 0, err;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [2:0] timer_underflow = 0;
    logic [3:0] skip_test = 0, ctx_acc_a, ctx_acc_b, restore_acc_a, restore_acc_b;
    logic [12:0] branch_target = 0, return_stack_pop, return_stack_entry;
    logic pready, pslverr, irq, mc_tick, instr_done, instr_multi, skip_taken, stack_push, restore_valid;
    logic ctx_carry, ctx_skip, restore_carry, restore_skip, irq_taken, global_irq_enable;
    logic pin_edge_request_flag, first_timer_request_flag, second_timer_request_flag, third_timer_request_flag;
    logic [1:0] instr_words, irq_source;
    logic [5:0] pc_page_part;
    logic [6:0] pc_in_page_part;
    logic [9:0] ctx_dp, restore_dp;
    logic [6:0] vec_row [4] = '{VEC_PIN, VEC_T1, VEC_T2, VEC_T3};  // expected vector per source
    int num_errors = 0, checked = 0, k, hit;
    wire [3:0] flags = {third_timer_request_flag, second_timer_request_flag,
                        first_timer_request_flag, pin_edge_request_flag};
    vectored_irq_sequencer vectored_irq_sequencer_inst (.*);
    cpu_seq_model cpu_seq_model_inst (.*);
    // free-running clock
    initial forever #5 pclk = ~pclk;
    task finish_test;
        $display("mismatches %0d comparisons %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // one apb transfer, data taken at the edge where pready is seen
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk) begin psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d; end
        @(posedge pclk) penable <= 1;
        hit = 0;
        for (n = 0; n < 20 && !hit; n++) begin
            @(posedge pclk) hit = (pready === 1'b1);
            if (hit) begin rd = prdata; err = pslverr; end
        end
        if (!hit) begin num_errors++; finish_test; end
        psel <= 0; penable <= 0;
    endtask
    // bounded wait for a pulse, returns at the negedge it is seen
    task automatic wt(ref logic s);
        int n;
        for (n = 0; n < 60 && s !== 1'b1; n++) @(negedge pclk);
        if (s !== 1'b1) begin num_errors++; finish_test; end
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1;
        apb(0, OFS_EN_A, 0); `CHK("en_a reset", 32'h0, rd)
        apb(0, 8'h18, 0); `CHK("unmapped err", 1'b1, err)
        $display("reset and map test done");
        timer_underflow <= 3'h4; @(posedge pclk) timer_underflow <= 0;
        wt(third_timer_request_flag);
        @(posedge pclk) skip_test <= 4'h8; @(posedge pclk) skip_test <= 0;
        wt(skip_taken); `CHK("t3 skip clear", 1'b0, third_timer_request_flag)
        @(posedge pclk); apb(1, OFS_EN_B, 1);
        timer_underflow <= 3'h4; @(posedge pclk) timer_underflow <= 0;
        wt(third_timer_request_flag);
        @(posedge pclk) skip_test <= 4'h8; @(posedge pclk) skip_test <= 0;
        repeat (3) @(negedge pclk); `CHK("t3 skip blocked", 1'b1, third_timer_request_flag)
        @(posedge pclk); apb(0, OFS_STATUS, 0); `CHK("status t3", 1'b1, rd[3])
        apb(1, OFS_MASK, 32'h1F); @(negedge pclk) `CHK("irq high", 1'b1, irq)
        @(posedge pclk); apb(1, OFS_STATUS, 32'h1F); @(negedge pclk) `CHK("irq low", 1'b0, irq)
        $display("skip and status test done");
        @(posedge pclk); apb(1, OFS_EN_A, 32'hD);
        pin_edge_in <= 0; timer_underflow <= 3'h7; @(posedge pclk) timer_underflow <= 0;
        repeat (6) @(posedge pclk);
        @(negedge pclk) `CHK("flags all", 4'hF, flags)
        for (k = 0; k < 4; k++) begin
            @(posedge pclk) irq_on_instr <= 1; @(posedge pclk) irq_on_instr <= 0;
            wt(global_irq_enable);
            for (hit = 0; hit < 9 && irq_taken !== 1'b1; hit++) @(negedge pclk);
            `CHK("latency", 1'b1, hit == 4 || hit == 6)
            wt(irq_taken);
            `CHK("source", k[1:0], irq_source)
            `CHK("vector", vec_row[k], pc_in_page_part)
            `CHK("page", 6'h1, pc_page_part)
            `CHK("range", 1'b1, {3'h0, pc_page_part, pc_in_page_part} inside {[VEC_RANGE_LO:VEC_RANGE_HI]})
            `CHK("gie", 1'b0, global_irq_enable)
            `CHK("left flags", 4'hF << (k + 1), flags)
            @(posedge pclk) irq_return_instr <= 1; @(posedge pclk) irq_return_instr <= 0;
            wt(restore_valid);
            `CHK("dp", 10'h2A5, restore_dp)
            `CHK("acc", 10'h296, {restore_carry, restore_skip, restore_acc_a, restore_acc_b})
        end
        $display("priority sweep done");
        @(posedge pclk); apb(1, OFS_EN_A, 0);
        irq_on_instr <= 1; timer_underflow <= 3'h1; @(posedge pclk) irq_on_instr <= 0; timer_underflow <= 0;
        @(negedge pclk) `CHK("gie waits", 1'b0, global_irq_enable)
        repeat (12) @(posedge pclk);
        @(negedge pclk) `CHK("disabled t1 kept", 1'b1, first_timer_request_flag)
        `CHK("gie on", 1'b1, global_irq_enable)
        @(posedge pclk) irq_off_instr <= 1; @(posedge pclk) irq_off_instr <= 0;
        @(negedge pclk) `CHK("gie off", 1'b0, global_irq_enable)
        @(posedge pclk) begin branch_target <= 13'h07F; branch_load <= 1; end
        repeat (2) @(posedge pclk); branch_load <= 0;
        @(negedge pclk) `CHK("branch", 13'h07F, {pc_page_part, pc_in_page_part})
        repeat (2) @(posedge pclk);
        @(negedge pclk) `CHK("roll", 13'h080, {pc_page_part, pc_in_page_part})
        $display("enable gating test done");
        finish_test;
    end
endmodule
bind vectored_irq_sequencer irq_seq_checker #(.PAGE_W(PAGE_W)) irq_seq_checker_inst (.*);
